// ### logic/snc_regs.sv
// Node configuration and status register bank of the packet switch.
`include "snc_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module snc_regs
	import snc_pkg::*;
#(
	parameter logic [7:0]  NUM_LINKS      = 8'h08,
	parameter logic [7:0]  NUM_SW_PROCS   = 8'h02,
	parameter logic [7:0]  NUM_DEV_PROCS  = 8'h02,
	parameter logic [31:0] SCAN_ID_WORD   = 32'h0000_0001, // Arbitrary value.
	parameter logic [17:0] METAL_ID_CODE  = 18'h00001,     // Arbitrary value.
	parameter logic [31:0] PLL_RESET_WORD = 32'h0000_0000
) (
	// Clock and reset.
	input  wire  logic         i_clk,
	input  wire  logic         i_reset_n,
	// Configuration access port.
	input  wire  snc_cfg_req_s i_cfg_req,
	output var   snc_cfg_rsp_s o_cfg_rsp,
	// Fixed inputs from one-time-programmable storage.
	input  wire  logic [13:0]  i_otp_usercode,
	// Settings driven to the switch and clock generator.
	output logic               o_one_byte_hdr,
	output logic [15:0]        o_node_id,
	output var   snc_pll_s     o_pll,
	output logic [15:0]        o_switch_div,
	output logic [15:0]        o_ref_div,
	output logic               o_tile_reset,
	// Routing lookup.
	input  wire  logic         i_route_valid,
	input  wire  logic [15:0]  i_route_dest,
	output logic               o_route_valid,
	output logic               o_route_local,
	output logic [3:0]         o_route_dir,
	// Processor debug state and requests.
	input  wire  logic [1:0]   i_in_debug_flag,
	output logic [1:0]         o_debug_req,
	// Open-drain global debug pin, active low.
	input  wire  logic         i_debug_pin_n,
	output logic               o_debug_pin_out,
	output logic               o_debug_pin_oe_n
);

	// Stored register state.
	logic [31:0]  swcfg_r;
	logic [15:0]  node_id_r;
	logic [31:0]  pll_r;
	logic [15:0]  swdiv_r;
	logic [15:0]  refdiv_r;
	logic [63:0]  dirs_r;
	logic [1:0]   dbg0_r;
	logic [1:0]   dbg1_r;
	logic [4:0]   dbgsrc_r;
	logic         tile_reset_r;
	snc_cfg_rsp_s rsp_r;
	snc_cfg_rsp_s rsp_nxt;

	// Routing pipeline state.
	logic         route_valid_r;
	logic         route_local_r;
	logic [3:0]   route_dir_r;

	// Debug line state.
	logic         pin_meta_r;
	logic         pin_sync_r;
	logic         drive_r;
	logic         drive_d1_r;
	logic         drive_d2_r;
	logic         global_r;
	logic [1:0]   debug_req_r;

	// Access qualification.
	wire          wr_req;
	wire          lock_all;
	wire          lock_pll;
	wire          wr_ok;
	wire          pll_ok;

	// Register selects.
	wire          sel_desc;
	wire          sel_swcfg;
	wire          sel_node;
	wire          sel_pll;
	wire          sel_swdiv;
	wire          sel_refdiv;
	wire          sel_scan;
	wire          sel_user;
	wire          sel_dlo;
	wire          sel_dhi;
	wire          sel_dbg0;
	wire          sel_dbg1;
	wire          sel_src;
	wire          sel_any;

	// Write strobes.
	wire          we_swcfg;
	wire          we_node;
	wire          we_pll;
	wire          we_swdiv;
	wire          we_refdiv;
	wire          we_dlo;
	wire          we_dhi;
	wire          we_dbg0;
	wire          we_dbg1;
	wire          we_src;
	wire          locked_hit;

	// Routing and debug combinational terms.
	wire [15:0]   mismatch;
	wire [3:0]    dim;
	wire [3:0]    dir_sel;
	wire          tile0_src;
	wire          tile1_src;
	wire          tile_drive;
	wire          pin_low;
	wire          ext_src;
	wire          global_now;
	wire          global_rise;

	// Finds the most significant set bit of a mismatch vector.
	function automatic logic [3:0] snc_msb(input logic [15:0] d);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (d[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : snc_msb

	// Lock bits taken from the switch configuration register.
	assign lock_all   = swcfg_r[`SNC_SWCFG_LOCK_ALL];
	assign lock_pll   = swcfg_r[`SNC_SWCFG_LOCK_PLL];
	assign wr_req     = i_cfg_req.valid & i_cfg_req.write;
	assign wr_ok      = wr_req & ~lock_all;
	assign pll_ok     = wr_ok & ~lock_pll;

	// Register number decode.
	assign sel_desc   = (i_cfg_req.num == `SNC_REG_DESC);
	assign sel_swcfg  = (i_cfg_req.num == `SNC_REG_SWCFG);
	assign sel_node   = (i_cfg_req.num == `SNC_REG_NODEID);
	assign sel_pll    = (i_cfg_req.num == `SNC_REG_PLL);
	assign sel_swdiv  = (i_cfg_req.num == `SNC_REG_SWDIV);
	assign sel_refdiv = (i_cfg_req.num == `SNC_REG_REFDIV);
	assign sel_scan   = (i_cfg_req.num == `SNC_REG_SCANID);
	assign sel_user   = (i_cfg_req.num == `SNC_REG_USERCODE);
	assign sel_dlo    = (i_cfg_req.num == `SNC_REG_DIR_LO);
	assign sel_dhi    = (i_cfg_req.num == `SNC_REG_DIR_HI);
	assign sel_dbg0   = (i_cfg_req.num == `SNC_REG_DBG0);
	assign sel_dbg1   = (i_cfg_req.num == `SNC_REG_DBG1);
	assign sel_src    = (i_cfg_req.num == `SNC_REG_DBGSRC);
	assign sel_any    = sel_desc | sel_swcfg | sel_node | sel_pll
	                  | sel_swdiv | sel_refdiv | sel_scan | sel_user
	                  | sel_dlo | sel_dhi | sel_dbg0 | sel_dbg1 | sel_src;

	// Write strobes; a locked write produces none of them.
	assign we_swcfg   = wr_ok & sel_swcfg;
	assign we_node    = wr_ok & sel_node;
	assign we_pll     = pll_ok & sel_pll;
	assign we_swdiv   = wr_ok & sel_swdiv;
	assign we_refdiv  = wr_ok & sel_refdiv;
	assign we_dlo     = wr_ok & sel_dlo;
	assign we_dhi     = wr_ok & sel_dhi;
	assign we_dbg0    = wr_ok & sel_dbg0;
	assign we_dbg1    = wr_ok & sel_dbg1;
	assign we_src     = wr_ok & sel_src;

	// A write to a writable register that a lock stopped is reported as refused.
	assign locked_hit = wr_req & (lock_all | (lock_pll & sel_pll))
	                  & (sel_swcfg | sel_node | sel_pll | sel_swdiv
	                  | sel_refdiv | sel_dlo | sel_dhi | sel_dbg0
	                  | sel_dbg1 | sel_src);

	// Read data selection; unmapped numbers and reserved bits read zero.
	always_comb begin
		rsp_nxt         = '0;
		rsp_nxt.ack     = i_cfg_req.valid;
		rsp_nxt.refused = i_cfg_req.valid & (~sel_any | locked_hit);
		if (i_cfg_req.write) begin
			rsp_nxt.rdata = 32'h0000_0000;
		end else if (sel_desc) begin
			rsp_nxt.rdata = {8'h00, NUM_LINKS, NUM_SW_PROCS, NUM_DEV_PROCS};
		end else if (sel_swcfg) begin
			rsp_nxt.rdata = swcfg_r;
		end else if (sel_node) begin
			rsp_nxt.rdata = {16'h0000, node_id_r};
		end else if (sel_pll) begin
			rsp_nxt.rdata = pll_r;
		end else if (sel_swdiv) begin
			rsp_nxt.rdata = {16'h0000, swdiv_r};
		end else if (sel_refdiv) begin
			rsp_nxt.rdata = {16'h0000, refdiv_r};
		end else if (sel_scan) begin
			rsp_nxt.rdata = SCAN_ID_WORD;
		end else if (sel_user) begin
			rsp_nxt.rdata = {i_otp_usercode, METAL_ID_CODE};
		end else if (sel_dlo) begin
			rsp_nxt.rdata = dirs_r[31:0];
		end else if (sel_dhi) begin
			rsp_nxt.rdata = dirs_r[63:32];
		end else if (sel_dbg0) begin
			rsp_nxt.rdata = {30'h0, dbg0_r};
		end else if (sel_dbg1) begin
			rsp_nxt.rdata = {30'h0, dbg1_r};
		end else if (sel_src) begin
			rsp_nxt.rdata = {27'h000_0000, dbgsrc_r};
		end else begin
			rsp_nxt.rdata = 32'h0000_0000;
		end
	end

	// Answer register: one answer per request, one cycle later.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	// Switch configuration: lock bits and header mode; reserved bits masked.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			swcfg_r <= 32'h0000_0000;
		end else if (we_swcfg) begin
			swcfg_r <= i_cfg_req.wdata & `SNC_SWCFG_MASK;
		end
	end

	// Node identifier and the two clock dividers.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			node_id_r <= `SNC_NODEID_RESET;
			swdiv_r   <= `SNC_SWDIV_RESET;
			refdiv_r  <= `SNC_REFDIV_RESET;
		end else begin
			if (we_node) begin
				node_id_r <= i_cfg_req.wdata[15:0];
			end
			if (we_swdiv) begin
				swdiv_r <= i_cfg_req.wdata[15:0];
			end
			if (we_refdiv) begin
				refdiv_r <= i_cfg_req.wdata[15:0];
			end
		end
	end

	// Clock-multiplier settings and the tile reset that a write starts.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pll_r        <= PLL_RESET_WORD & `SNC_PLL_MASK;
			tile_reset_r <= 1'b0;
		end else begin
			if (we_pll) begin
				pll_r <= i_cfg_req.wdata & `SNC_PLL_MASK;
			end
			tile_reset_r <= we_pll & ~i_cfg_req.wdata[`SNC_PLL_NO_RESET];
		end
	end

	// Routing direction tables, eight four-bit fields per register.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dirs_r <= 64'h0000_0000_0000_0000;
		end else begin
			if (we_dlo) begin
				dirs_r[31:0] <= i_cfg_req.wdata;
			end
			if (we_dhi) begin
				dirs_r[63:32] <= i_cfg_req.wdata;
			end
		end
	end

	// Routing lookup: dimension is the top mismatching node-identifier bit.
	assign mismatch = i_route_dest ^ node_id_r;
	assign dim      = snc_msb(mismatch);
	assign dir_sel  = dirs_r[{dim, 2'b00} +: 4];

	// Registered routing answer, one cycle after the lookup request.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			route_valid_r <= 1'b0;
			route_local_r <= 1'b0;
			route_dir_r   <= 4'h0;
		end else begin
			route_valid_r <= i_route_valid;
			route_local_r <= (mismatch == 16'h0000);
			route_dir_r   <= dir_sel;
		end
	end

	// Per-tile debug line configuration.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dbg0_r <= 2'b00;
			dbg1_r <= 2'b00;
		end else begin
			if (we_dbg0) begin
				dbg0_r <= i_cfg_req.wdata[1:0];
			end
			if (we_dbg1) begin
				dbg1_r <= i_cfg_req.wdata[1:0];
			end
		end
	end

	// Tiles that may drive the global debug line and an external driver seen on the pin.
	assign tile0_src  = i_in_debug_flag[0] & dbg0_r[`SNC_DBG_DRIVE_EN];
	assign tile1_src  = i_in_debug_flag[1] & dbg1_r[`SNC_DBG_DRIVE_EN];
	assign tile_drive = tile0_src | tile1_src;
	assign pin_low    = ~pin_sync_r;
	assign ext_src    = pin_low & ~drive_d2_r;
	assign global_now = tile_drive | ext_src;
	assign global_rise = global_now & ~global_r;

	// Pin synchroniser and the delay line matching our own drive to it.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
			drive_r    <= 1'b0;
			drive_d1_r <= 1'b0;
			drive_d2_r <= 1'b0;
		end else begin
			pin_meta_r <= i_debug_pin_n;
			pin_sync_r <= pin_meta_r;
			drive_r    <= tile_drive;
			drive_d1_r <= drive_r;
			drive_d2_r <= drive_d1_r;
		end
	end

	// Global line state and the debug requests it raises.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			global_r    <= 1'b0;
			debug_req_r <= 2'b00;
		end else begin
			global_r    <= global_now;
			debug_req_r <= {global_now & dbg1_r[`SNC_DBG_REQ_EN],
			                global_now & dbg0_r[`SNC_DBG_REQ_EN]};
		end
	end

	// Debug source: a new event wins over a software write in the same cycle.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dbgsrc_r <= 5'h00;
		end else if (global_rise) begin
			dbgsrc_r <= {ext_src, 2'b00, tile1_src, tile0_src};
		end else if (we_src) begin
			dbgsrc_r <= i_cfg_req.wdata[4:0] & 5'(`SNC_DBGSRC_MASK);
		end
	end

	// Outputs, straight from flip-flops apart from the tied-low pin data.
	assign o_cfg_rsp        = rsp_r;
	assign o_one_byte_hdr   = swcfg_r[`SNC_SWCFG_HDR1];
	assign o_node_id        = node_id_r;
	assign o_pll.no_reset   = pll_r[`SNC_PLL_NO_RESET];
	assign o_pll.no_relock  = pll_r[`SNC_PLL_NO_RELOCK];
	assign o_pll.bypass     = pll_r[`SNC_PLL_BYPASS];
	assign o_pll.boot_scan  = pll_r[`SNC_PLL_BOOT_SCAN];
	assign o_pll.output_divider = pll_r[25:23];
	assign o_pll.fb_mul     = pll_r[20:8];
	assign o_pll.in_div     = pll_r[6:0];
	assign o_switch_div     = swdiv_r;
	assign o_ref_div        = refdiv_r;
	assign o_tile_reset     = tile_reset_r;
	assign o_route_valid    = route_valid_r;
	assign o_route_local    = route_local_r;
	assign o_route_dir      = route_dir_r;
	assign o_debug_req      = debug_req_r;
	// Open-drain: the data is always low; the enable decides whether it pulls.
	assign o_debug_pin_out  = 1'b0;
	assign o_debug_pin_oe_n = ~drive_r;

endmodule : snc_regs
`default_nettype wire

// ### common/snc_consts.svh
// Register numbers, field positions, reset values and timing of the node config bank.
`ifndef SNC_CONSTS_SVH
`define SNC_CONSTS_SVH
`define SNC_REG_DESC        8'h01
`define SNC_REG_SWCFG       8'h04
`define SNC_REG_NODEID      8'h05
`define SNC_REG_PLL         8'h06
`define SNC_REG_SWDIV       8'h07
`define SNC_REG_REFDIV      8'h08
`define SNC_REG_SCANID      8'h09
`define SNC_REG_USERCODE    8'h0A
`define SNC_REG_DIR_LO      8'h0C
`define SNC_REG_DIR_HI      8'h0D
`define SNC_REG_DBG0        8'h10
`define SNC_REG_DBG1        8'h11
`define SNC_REG_DBGSRC      8'h1F
`define SNC_SWCFG_LOCK_ALL  31
`define SNC_SWCFG_LOCK_PLL  8
`define SNC_SWCFG_HDR1      0
`define SNC_PLL_NO_RESET    31
`define SNC_PLL_NO_RELOCK   30
`define SNC_PLL_BYPASS      29
`define SNC_PLL_BOOT_SCAN   28
`define SNC_DBG_REQ_EN      1
`define SNC_DBG_DRIVE_EN    0
`define SNC_SRC_PIN         4
`define SNC_SRC_TILE1       1
`define SNC_SRC_TILE0       0
`define SNC_SWCFG_MASK      32'h8000_0101
`define SNC_PLL_MASK        32'hF3FF_FF7F
`define SNC_DBGCFG_MASK     32'h0000_0003
`define SNC_DBGSRC_MASK     32'h0000_0013
`define SNC_NODEID_RESET    16'h0000
`define SNC_SWDIV_RESET     16'h0000
`define SNC_REFDIV_RESET    16'h0003
`define SNC_RSP_LATENCY     1
`endif

// ### common/snc_pkg.sv
// Types shared by the node configuration register bank.
`default_nettype none
package snc_pkg;
	// One configuration read or write, addressed by register number.
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  num;
		logic [31:0] wdata;
	} snc_cfg_req_s;
	// Answer to a configuration access.
	typedef struct packed {
		logic        ack;
		logic        refused;
		logic [31:0] rdata;
	} snc_cfg_rsp_s;
	// Clock-multiplier settings as held and driven to the clock generator.
	typedef struct packed {
		logic        no_reset;
		logic        no_relock;
		logic        bypass;
		logic        boot_scan;
		logic [2:0]  output_divider;
		logic [12:0] fb_mul;
		logic [6:0]  in_div;
	} snc_pll_s;
endpackage : snc_pkg
`default_nettype wire

// ### test/snc_regs_asserts.sv
// Concurrent checks on the ports of the node configuration register bank.
`include "snc_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module snc_regs_asserts
	import snc_pkg::*;
(
	// Clock and reset.
	input wire logic         i_clk,
	input wire logic         i_reset_n,
	// Configuration access port.
	input wire snc_cfg_req_s i_cfg_req,
	input wire snc_cfg_rsp_s o_cfg_rsp,
	// Settings outputs.
	input wire logic         o_one_byte_hdr,
	input wire logic [15:0]  o_node_id,
	input wire snc_pll_s     o_pll,
	input wire logic [15:0]  o_ref_div,
	input wire logic         o_tile_reset,
	// Routing lookup.
	input wire logic         i_route_valid,
	input wire logic [15:0]  i_route_dest,
	input wire logic         o_route_valid,
	input wire logic         o_route_local
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Decoded accesses seen at the request port.
	wire logic     wr_en   = i_cfg_req.valid & i_cfg_req.write;
	wire logic     wr_pll  = wr_en & (i_cfg_req.num == `SNC_REG_PLL);
	wire logic     wr_nid  = wr_en & (i_cfg_req.num == `SNC_REG_NODEID);
	wire logic     wr_cfg  = wr_en & (i_cfg_req.num == `SNC_REG_SWCFG);
	wire logic     wr_ref  = wr_en & (i_cfg_req.num == `SNC_REG_REFDIV);
	wire logic     rd_nid  = i_cfg_req.valid & ~i_cfg_req.write & (i_cfg_req.num == `SNC_REG_NODEID);
	wire snc_pll_s pll_img = {i_cfg_req.wdata[31:28], i_cfg_req.wdata[25:23],
		i_cfg_req.wdata[20:8], i_cfg_req.wdata[6:0]};

	ack_follows_a: assert property (i_cfg_req.valid |=> o_cfg_rsp.ack)
		else $error("access not answered in the next cycle");
	ack_needs_req_a: assert property (!i_cfg_req.valid |=> !o_cfg_rsp.ack)
		else $error("answer without a request");
	tile_reset_cause_a: assert property (o_tile_reset |-> o_cfg_rsp.ack && !o_cfg_rsp.refused
		&& $past(wr_pll && !i_cfg_req.wdata[31]))
		else $error("tile reset without an accepted unsuppressed multiplier write");
	tile_reset_issue_a: assert property (wr_pll && !i_cfg_req.wdata[31]
		|=> o_tile_reset != o_cfg_rsp.refused)
		else $error("multiplier write gave wrong tile reset");
	pll_fields_a: assert property (wr_pll |=> o_cfg_rsp.refused || o_pll == $past(pll_img))
		else $error("multiplier fields differ from written value");
	node_id_write_a: assert property (wr_nid
		|=> o_cfg_rsp.refused || o_node_id == $past(i_cfg_req.wdata[15:0]))
		else $error("node identifier not updated");
	node_id_read_a: assert property (rd_nid ##1 1'b1
		|-> o_cfg_rsp.rdata == {16'h0000, $past(o_node_id)})
		else $error("node identifier read back wrong");
	route_answer_a: assert property (i_route_valid |=> o_route_valid
		&& o_route_local == ($past(i_route_dest) == $past(o_node_id)))
		else $error("route answer wrong");
	hdr_hold_a: assert property (!wr_cfg |=> $stable(o_one_byte_hdr))
		else $error("header mode changed without a write");
	ref_hold_a: assert property ($changed(o_ref_div) |-> $past(wr_ref))
		else $error("reference divider changed without a write");
	refused_zero_a: assert property (o_cfg_rsp.refused |-> o_cfg_rsp.ack
		&& o_cfg_rsp.rdata == 32'h0000_0000)
		else $error("refused answer carries data");
endmodule : snc_regs_asserts

bind snc_regs snc_regs_asserts u_snc_regs_asserts (
	.i_clk, .i_reset_n, .i_cfg_req, .o_cfg_rsp, .o_one_byte_hdr, .o_node_id, .o_pll,
	.o_ref_div, .o_tile_reset, .i_route_valid, .i_route_dest, .o_route_valid, .o_route_local
);
`default_nettype wire

// ### test/snc_requester.sv
// Model of a requester issuing numbered configuration reads and writes.
`timescale 1ns/1ns
`default_nettype none
module snc_requester
	import snc_pkg::*;
(
	// Clock.
	input  wire logic         i_clk,
	// Request out, answer in.
	output var  snc_cfg_req_s o_req,
	input  wire snc_cfg_rsp_s i_rsp
);
	// No request while the bank is still in reset.
	initial begin
		o_req = '0;
	end

	// One access: driven after the next edge and taken at the edge after, address and data scrambled once released.
	task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] wd,
		output snc_cfg_rsp_s rsp);
		@(posedge i_clk);
		o_req <= '{valid: 1'b1, write: wr, num: num, wdata: wd};
		@(posedge i_clk);
		o_req.valid <= 1'b0;
		o_req.num   <= ~num;
		o_req.wdata <= ~wd;
		@(posedge i_clk);
		rsp = i_rsp;
	endtask : access
endmodule : snc_requester
`default_nettype wire

// ### test/snc_regs_test.sv
// Self-checking bench for the node configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module snc_regs_test
	import snc_pkg::*;
;
	logic         clk      = 1'b0;
	logic         rst_n    = 1'b0;
	logic         rt_v     = 1'b0;
	logic [15:0]  rt_dest  = 16'h0000;
	logic [1:0]   in_dbg   = 2'b00;
	logic         ext_pull = 1'b0;
	logic [13:0]  otp_uc   = 14'h2A5B;
	snc_cfg_req_s req;
	snc_cfg_rsp_s rsp;
	snc_pll_s     pll;
	logic         hdr, tile_rst, rt_vo, rt_loc, pin_out, oe_n;
	logic [15:0]  nid, sw_div, ref_div;
	logic [3:0]   rt_dir;
	logic [1:0]   dbg_req;
	int           n_errors = 0;
	int           num_checks = 0;
	int           n_resets = 0;
	// Pin pulled up; low when the bank or the outside pulls it.
	wire logic    pin_n = ~ext_pull & (oe_n | pin_out);
	// Reset values, then images after writing all ones (lock bits kept clear at 04), per register number.
	localparam logic [7:0]  RNUM [12] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h0A, 8'h0C, 8'h0D, 8'h10, 8'h11};
	localparam logic [31:0] RRST [12] = '{32'h0003_0204, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3,
		32'h0000_5A5A, {14'h2A5B, 18'h2_4C31}, 32'h0, 32'h0, 32'h0, 32'h0};
	localparam logic [7:0]  WNUM [11] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0C,
		8'h0D, 8'h10, 8'h11, 8'h1F};
	localparam logic [31:0] WEXP [11] = '{32'h0003_0204, 32'h1, 32'hFFFF, 32'hF3FF_FF7F,
		32'hFFFF, 32'hFFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h3, 32'h3, 32'h13};

	// Identification values are arbitrary.
	snc_regs #(.NUM_LINKS(8'h03), .NUM_SW_PROCS(8'h02), .NUM_DEV_PROCS(8'h04),
		.SCAN_ID_WORD(32'h0000_5A5A), .METAL_ID_CODE(18'h2_4C31)) u_snc_regs (
		.i_clk(clk), .i_reset_n(rst_n), .i_cfg_req(req), .o_cfg_rsp(rsp),
		.i_otp_usercode(otp_uc), .o_one_byte_hdr(hdr), .o_node_id(nid), .o_pll(pll),
		.o_switch_div(sw_div), .o_ref_div(ref_div), .o_tile_reset(tile_rst),
		.i_route_valid(rt_v), .i_route_dest(rt_dest), .o_route_valid(rt_vo),
		.o_route_local(rt_loc), .o_route_dir(rt_dir), .i_in_debug_flag(in_dbg),
		.o_debug_req(dbg_req), .i_debug_pin_n(pin_n), .o_debug_pin_out(pin_out),
		.o_debug_pin_oe_n(oe_n));
	snc_requester u_snc_requester (.i_clk(clk), .o_req(req), .i_rsp(rsp));

	// Clock and tile reset pulse count.
	always #5 clk = ~clk;
	// Pulses are counted on the falling edge, so the count is settled when the answer is taken.
	always @(negedge clk) begin
		if (tile_rst === 1'b1) begin
			n_resets <= n_resets + 1;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic acc(input logic wr, input logic [7:0] num, input logic [31:0] wd,
		input logic [31:0] exp, input logic refd);
		snc_cfg_rsp_s r;
		u_snc_requester.access(wr, num, wd, r);
		check({r.refused, r.ack}, {refd, 1'b1}, "answer flags");
		check(r.rdata, exp, "read data");
	endtask : acc

	task automatic route(input logic [15:0] dest, input logic loc, input logic [3:0] dir);
		@(posedge clk);
		rt_v    <= 1'b1;
		rt_dest <= dest;
		@(posedge clk);
		rt_v    <= 1'b0;
		rt_dest <= ~dest;
		@(posedge clk);
		check({rt_vo, rt_loc, loc ? 4'h0 : rt_dir}, {1'b1, loc, dir}, "route answer");
	endtask : route

	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out

	// Watchdog against a hung run.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		close_out();
	end

	// Main sequence.
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		check(ref_div, 16'h3, "reset divider");
		for (int i = 0; i < 12; i++) acc(1'b0, RNUM[i], 32'h0, RRST[i], 1'b0);
		otp_uc <= 14'h1C3E;
		acc(1'b0, 8'h0A, 32'h0, {14'h1C3E, 18'h2_4C31}, 1'b0);
		for (int i = 0; i < 11; i++) begin
			acc(1'b1, WNUM[i], (i == 1) ? 32'h7FFF_FEFF : 32'hFFFF_FFFF, 32'h0, 1'b0);
			acc(1'b0, WNUM[i], 32'h0, WEXP[i], 1'b0);
		end
		check(32'({hdr, sw_div}), 32'h0001_FFFF, "settings out");
		check(32'(pll), 32'h07FF_FFFF, "multiplier fields");
		check(n_resets, 0, "suppressed reset");
		acc(1'b0, 8'h02, 32'h0, 32'h0, 1'b1);
		acc(1'b1, 8'h1E, 32'hFFFF_FFFF, 32'h0, 1'b1);
		acc(1'b1, 8'h05, 32'h0000_00A5, 32'h0, 1'b0);
		acc(1'b1, 8'h0C, 32'h7654_3210, 32'h0, 1'b0);
		acc(1'b1, 8'h0D, 32'hFEDC_BA98, 32'h0, 1'b0);
		route(16'h00A5, 1'b1, 4'h0);
		for (int d = 0; d < 16; d++) route(16'h00A5 ^ (16'hFFFF >> (15 - d)), 1'b0, 4'(d));
		acc(1'b1, 8'h06, 32'h0000_1234, 32'h0, 1'b0);
		check(n_resets, 1, "tile reset");
		check(32'(pll), 32'h0000_0934, "multiplier fields");
		acc(1'b1, 8'h06, 32'h8000_1234, 32'h0, 1'b0);
		check(n_resets, 1, "suppressed reset");
		acc(1'b1, 8'h10, 32'h1, 32'h0, 1'b0);
		acc(1'b1, 8'h11, 32'h2, 32'h0, 1'b0);
		acc(1'b1, 8'h1F, 32'h0, 32'h0, 1'b0);
		in_dbg <= 2'b01;
		repeat (4) @(posedge clk);
		check({oe_n, dbg_req}, 3'b010, "tile drives line");
		acc(1'b0, 8'h1F, 32'h0, 32'h1, 1'b0);
		in_dbg <= 2'b00;
		repeat (8) @(posedge clk);
		check({oe_n, dbg_req}, 3'b100, "line released");
		acc(1'b1, 8'h1F, 32'h0, 32'h0, 1'b0);
		ext_pull <= 1'b1;
		repeat (6) @(posedge clk);
		check({oe_n, dbg_req}, 3'b110, "pin raises request");
		acc(1'b0, 8'h1F, 32'h0, 32'h10, 1'b0);
		ext_pull <= 1'b0;
		acc(1'b1, 8'h04, 32'h100, 32'h0, 1'b0);
		acc(1'b1, 8'h06, 32'h0000_5678, 32'h0, 1'b1);
		check(n_resets, 1, "locked multiplier reset");
		check(32'(pll), 32'h0400_0934, "locked multiplier");
		acc(1'b1, 8'h05, 32'h1111, 32'h0, 1'b0);
		acc(1'b1, 8'h04, 32'h8000_0000, 32'h0, 1'b0);
		acc(1'b1, 8'h05, 32'h2222, 32'h0, 1'b1);
		acc(1'b0, 8'h05, 32'h0, 32'h1111, 1'b0);
		acc(1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check({ref_div, nid}, {16'h3, 16'h0}, "second reset");
		acc(1'b0, 8'h04, 32'h0, 32'h0, 1'b0);
		close_out();
	end
endmodule : snc_regs_test
`default_nettype wire
